// file: hw/ocs_clock_switch.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
module ocs_clock_switch (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	// system integration side
	input wire logic systemOscEnable,
	output logic busClockQuad,
	output logic busClockDouble,
	// asynchronous source clocks
	input wire logic clockInPinIn,
	input wire logic resistorCapClock,
	input wire logic crystalClock,
	// pin control
	output logic clockInPinInputEnable,
	output logic clockOutPinOut,
	output logic clockOutPinOe,
	output logic crystalAmpEnable,
	// status
	output logic externalClockEngaged,
	output logic internalOscRunning
);

	typedef struct packed {
		logic [1:0] src;
		logic [1:0] ifs;
		logic [1:0] xr;
		logic req;
		logic outEn;
		logic keep;
		logic [7:0] trim;
		logic [7:0] rdData;
		ocs_pkg::ocs_state_t state;
		logic [1:0] edgeCnt;
		logic [1:0] engSrc;
		logic prevLevel;
		logic engaged;
		logic intRun;
		logic quad;
		logic double;
		logic inEn;
		logic pinOut;
		logic pinOe;
		logic ampEn;
	} ocs_sw_state_t;

	ocs_sw_state_t s_q;
	ocs_sw_state_t s_d;
	logic [2:0] rawClk;
	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	logic intLevel;
	logic extLevel;
	logic extRise;
	logic oscAllowed;
	logic [1:0] levelSrc;

	// external sources are asynchronous to ref_clk
	assign rawClk = {crystalClock, resistorCapClock, clockInPinIn};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					syncA_q[gi] <= 1'b0;
					syncB_q[gi] <= 1'b0;
				end else begin
					syncA_q[gi] <= rawClk[gi];
					syncB_q[gi] <= syncA_q[gi];
				end
			end
		end
	endgenerate

	function automatic logic pickLevel(input logic [1:0] sel, input logic [2:0] lv);
		logic r;
		r = 1'b0;
		case (sel)
			ocs_pkg::SRC_EXT: r = lv[0];
			ocs_pkg::SRC_RC: r = lv[1];
			ocs_pkg::SRC_XTAL: r = lv[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// once engaged the mux follows the source that was checked, not later writes
	assign levelSrc = s_q.engaged ? s_q.engSrc : s_q.src;
	assign extLevel = pickLevel(levelSrc, syncB_q);
	assign extRise = extLevel & ~s_q.prevLevel;
	assign oscAllowed = systemOscEnable | s_q.keep;

	ocs_int_osc u_int_osc (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(s_q.intRun),
		.freqSel(s_q.ifs),
		.trim(s_q.trim),
		.level(intLevel)
	);

	always_comb begin
		s_d = s_q;
		s_d.prevLevel = extLevel;
		s_d.rdData = 8'h00;
		// registers; apart from reset, the trim is only loaded from here
		if (regWrStrobe) begin
			if (regAddr == ocs_pkg::ADDR_CTRL) begin
				s_d.src = regWrData[ocs_pkg::CTRL_SRC_LSB +: 2];
				s_d.ifs = regWrData[ocs_pkg::CTRL_IFS_LSB +: 2];
				s_d.xr = regWrData[ocs_pkg::CTRL_XR_LSB +: 2];
				s_d.req = regWrData[ocs_pkg::CTRL_REQ_BIT];
			end else if (regAddr == ocs_pkg::ADDR_TRIM) begin
				s_d.trim = regWrData;
			end else if (regAddr == ocs_pkg::ADDR_PINCFG) begin
				s_d.outEn = regWrData[ocs_pkg::PINCFG_OUTEN_BIT];
				s_d.keep = regWrData[ocs_pkg::PINCFG_KEEP_BIT];
			end
		end
		if (regRdStrobe) begin
			if (regAddr == ocs_pkg::ADDR_CTRL) begin
				s_d.rdData = {s_q.src, s_q.ifs, s_q.xr, s_q.req, s_q.engaged};
			end else if (regAddr == ocs_pkg::ADDR_TRIM) begin
				s_d.rdData = s_q.trim;
			end else if (regAddr == ocs_pkg::ADDR_PINCFG) begin
				s_d.rdData = {6'h00, s_q.keep, s_q.outEn};
			end
		end
		// the pin keeps its other functions, so the bit cannot stay set
		if (s_d.src == ocs_pkg::SRC_EXT) begin
			s_d.outEn = 1'b0;
		end

		case (s_q.state)
			ocs_pkg::ST_INTERNAL: begin
				if (s_q.req && s_q.src != ocs_pkg::SRC_INT) begin
					s_d.state = ocs_pkg::ST_CHECK;
					s_d.edgeCnt = 2'h0;
				end
			end
			ocs_pkg::ST_CHECK: begin
				if (!s_q.req || s_q.src == ocs_pkg::SRC_INT) begin
					s_d.state = ocs_pkg::ST_INTERNAL;
				end else if (extRise) begin
					s_d.edgeCnt = s_q.edgeCnt + 2'h1;
					if (s_q.edgeCnt + 2'h1 == ocs_pkg::ACTIVITY_EDGES) begin
						s_d.state = ocs_pkg::ST_ENGAGE;
					end
				end
			end
			ocs_pkg::ST_ENGAGE: begin
				// both clocks low: the mux moves without a runt pulse
				// the old source is still on the mux for one more cycle, so it must be low too
				if (!s_q.quad && !intLevel && !extLevel) begin
					s_d.engaged = 1'b1;
					s_d.engSrc = s_q.src;
					s_d.state = ocs_pkg::ST_EXTERNAL;
				end
			end
			ocs_pkg::ST_EXTERNAL: begin
				if (!s_q.req && s_q.src == ocs_pkg::SRC_INT) begin
					s_d.state = ocs_pkg::ST_RELEASE;
				end
			end
			ocs_pkg::ST_RELEASE: begin
				if (!s_q.quad && !intLevel && !extLevel) begin
					s_d.engaged = 1'b0;
					s_d.state = ocs_pkg::ST_INTERNAL;
				end
			end
			default: begin
				s_d.state = ocs_pkg::ST_INTERNAL;
			end
		endcase

		// stops one cycle after the engaged bit rises
		s_d.intRun = oscAllowed && s_q.state != ocs_pkg::ST_EXTERNAL;

		// x4 follows the source level; no wait-mode input, so clocks never pause there
		s_d.quad = s_q.engaged ? extLevel : intLevel;
		if (s_d.quad && !s_q.quad) begin
			s_d.double = ~s_q.double;
		end

		s_d.inEn = s_q.src != ocs_pkg::SRC_INT || s_q.engaged;
		s_d.ampEn = s_q.src == ocs_pkg::SRC_XTAL && oscAllowed;
		if ((s_q.src == ocs_pkg::SRC_INT || s_q.src == ocs_pkg::SRC_RC) && s_q.outEn) begin
			s_d.pinOe = 1'b1;
			s_d.pinOut = s_d.quad;
		end else begin
			s_d.pinOe = 1'b0;
			s_d.pinOut = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.src <= ocs_pkg::SRC_RST;
			s_q.ifs <= ocs_pkg::IFS_RST;
			s_q.xr <= ocs_pkg::XR_RST;
			s_q.trim <= ocs_pkg::TRIM_RST;
			s_q.req <= 1'b0;
			s_q.state <= ocs_pkg::ST_INTERNAL;
			s_q.intRun <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// no interrupt output exists
	assign regRdData = s_q.rdData;
	assign busClockQuad = s_q.quad;
	assign busClockDouble = s_q.double;
	assign clockInPinInputEnable = s_q.inEn;
	assign clockOutPinOut = s_q.pinOut;
	assign clockOutPinOe = s_q.pinOe;
	assign crystalAmpEnable = s_q.ampEn;
	assign externalClockEngaged = s_q.engaged;
	assign internalOscRunning = s_q.intRun;

	property p_double_half;
		@(posedge ref_clk) disable iff (rst)
		$rose(busClockQuad) |-> busClockDouble != $past(busClockDouble);
	endproperty
	a_double_half: assert property (p_double_half) else $error("x2 clock did not toggle on x4 rise");

	property p_two_edges;
		@(posedge ref_clk) disable iff (rst)
		s_q.state == ocs_pkg::ST_ENGAGE |-> s_q.edgeCnt == 2'h2;
	endproperty
	a_two_edges: assert property (p_two_edges) else $error("switch began before two edges");

	property p_engage_order;
		@(posedge ref_clk) disable iff (rst)
		($rose(externalClockEngaged) && oscAllowed) |-> internalOscRunning ##1 !internalOscRunning;
	endproperty
	a_engage_order: assert property (p_engage_order) else $error("internal osc stopped out of order");

	property p_mux_low;
		@(posedge ref_clk) disable iff (rst)
		$changed(externalClockEngaged) |-> !busClockQuad && !$past(busClockQuad);
	endproperty
	a_mux_low: assert property (p_mux_low) else $error("clock mux changed while high");

	property p_ext_pin;
		@(posedge ref_clk) disable iff (rst)
		s_q.src == ocs_pkg::SRC_EXT |=> !clockOutPinOe && !s_q.outEn;
	endproperty
	a_ext_pin: assert property (p_ext_pin) else $error("out pin driven in external mode");

	property p_xtal_pin;
		@(posedge ref_clk) disable iff (rst)
		(s_q.src == ocs_pkg::SRC_XTAL && oscAllowed) |=> crystalAmpEnable && !clockOutPinOe;
	endproperty
	a_xtal_pin: assert property (p_xtal_pin) else $error("crystal pin not given to amplifier");

	property p_int_pin;
		@(posedge ref_clk) disable iff (rst)
		(s_q.src == ocs_pkg::SRC_INT && s_q.outEn) |=> clockOutPinOe && clockOutPinOut == busClockQuad;
	endproperty
	a_int_pin: assert property (p_int_pin) else $error("out pin not carrying x4 clock");

	property p_in_release;
		@(posedge ref_clk) disable iff (rst)
		(s_q.src == ocs_pkg::SRC_INT && !s_q.engaged) |=> !clockInPinInputEnable;
	endproperty
	a_in_release: assert property (p_in_release) else $error("input pin not released");

	property p_stop_off;
		@(posedge ref_clk) disable iff (rst)
		!oscAllowed |=> !internalOscRunning && !crystalAmpEnable;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("oscillator ran in stop");

	property p_reset_start;
		@(posedge ref_clk)
		rst |=> !s_q.req && !externalClockEngaged && s_q.ifs == ocs_pkg::IFS_4M0;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("reset did not start internal");

endmodule

// file: hw/ocs_int_osc.sv
`timescale 1ns/1ns
module ocs_int_osc (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic [1:0] freqSel,
	input wire logic [7:0] trim,
	// oscillator output
	output logic level
);

	typedef struct packed {
		logic [15:0] acc;
		logic level;
	} ocs_osc_state_t;

	ocs_osc_state_t s_q;
	ocs_osc_state_t s_d;
	logic [15:0] step;
	logic signed [15:0] delta;
	logic [15:0] adj;
	logic [16:0] sum;

	always_comb begin
		case (freqSel)
			ocs_pkg::IFS_8M0: step = ocs_pkg::STEP_8M0;
			ocs_pkg::IFS_12M8: step = ocs_pkg::STEP_12M8;
			default: step = ocs_pkg::STEP_4M0;
		endcase
	end

	// a larger trim shrinks the step, so the period grows and the frequency drops
	assign delta = 16'($signed(trim)) * 16'($signed({1'b0, step[15:ocs_pkg::TRIM_STEP_SHIFT]}));
	assign adj = step - 16'(delta);
	assign sum = {1'b0, s_q.acc} + {1'b0, adj};

	always_comb begin
		s_d = s_q;
		if (!run) begin
			// stopped low so the clock mux never sees a half pulse
			s_d.acc = 16'h0000;
			s_d.level = 1'b0;
		end else begin
			s_d.acc = sum[15:0];
			if (sum[16]) begin
				s_d.level = ~s_q.level;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.level;

endmodule

// file: inc/ocs_pkg.sv
package ocs_pkg;

	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TRIM = 8'h01;
	localparam logic [7:0] ADDR_PINCFG = 8'h02;

	// control register field positions
	localparam int CTRL_SRC_LSB = 6;
	localparam int CTRL_IFS_LSB = 4;
	localparam int CTRL_XR_LSB = 2;
	localparam int CTRL_REQ_BIT = 1;
	localparam int CTRL_ENG_BIT = 0;

	// pin configuration register field positions
	localparam int PINCFG_OUTEN_BIT = 0;
	localparam int PINCFG_KEEP_BIT = 1;

	// values after reset
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [1:0] IFS_RST = 2'h0;
	localparam logic [1:0] XR_RST = 2'h0;
	localparam logic [7:0] TRIM_RST = 8'h00;

	// source select encoding
	localparam logic [1:0] SRC_INT = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_RC = 2'h2;
	localparam logic [1:0] SRC_XTAL = 2'h3;

	// internal frequency select encoding
	localparam logic [1:0] IFS_4M0 = 2'h0;
	localparam logic [1:0] IFS_8M0 = 2'h1;
	localparam logic [1:0] IFS_12M8 = 2'h2;

	// accumulator steps of the internal oscillator model, in ratio 4.0 : 8.0 : 12.8
	localparam logic [15:0] STEP_4M0 = 16'h1400;
	localparam logic [15:0] STEP_8M0 = 16'h2800;
	localparam logic [15:0] STEP_12M8 = 16'h4000;
	localparam int TRIM_STEP_SHIFT = 9;

	// rising edges of the external source seen before the switch
	localparam logic [1:0] ACTIVITY_EDGES = 2'h2;

	typedef enum logic [2:0] {
		ST_INTERNAL,
		ST_CHECK,
		ST_ENGAGE,
		ST_EXTERNAL,
		ST_RELEASE
	} ocs_state_t;

endpackage

// file: verification/ocs_src_model.sv
`timescale 1ns/1ns
// far-side source clocks; each stands low while not running, as a stopped oscillator would
module ocs_src_model #(
	parameter int PIN_HALF = 350,
	parameter int RC_HALF = 450,
	parameter int XTAL_HALF = 270
) (
	// run controls
	input wire logic runPin,
	input wire logic runRc,
	input wire logic runXtal,
	// source clocks
	output logic pinClk,
	output logic resistor_cap_clock,
	output logic crystal_clock
);
	initial begin
		pinClk = 1'b0;
		resistor_cap_clock = 1'b0;
		crystal_clock = 1'b0;
	end
	always #(PIN_HALF) pinClk = runPin & ~pinClk;
	always #(RC_HALF) resistor_cap_clock = runRc & ~resistor_cap_clock;
	always #(XTAL_HALF) crystal_clock = runXtal & ~crystal_clock;
endmodule

// file: verification/tb_osc_clock_source_switch.sv
`timescale 1ns/1ns
module tb_osc_clock_source_switch;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrStrobe = 1'b0;
	logic regRdStrobe = 1'b0;
	logic systemOscEnable = 1'b1;
	logic runPin = 1'b0;
	logic runRc = 1'b0;
	logic runXtal = 1'b0;
	logic [7:0] regRdData, rdv;
	logic busClockQuad, busClockDouble, clockInPinIn, resistorCapClock, crystalClock;
	logic clockInPinInputEnable, clockOutPinOut, clockOutPinOe, crystalAmpEnable;
	logic externalClockEngaged, internalOscRunning;
	logic quadPrev = 1'b0;
	logic dblPrev = 1'b0;
	logic outPrev = 1'b0;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int quadRises, dblRises, outRises, pinRises, rcRises, xtalRises, c4, c8, c12, cHi, cLo;

	always #50 ref_clk = ~ref_clk;

	ocs_clock_switch u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.systemOscEnable(systemOscEnable), .busClockQuad(busClockQuad), .busClockDouble(busClockDouble),
		.clockInPinIn(clockInPinIn), .resistorCapClock(resistorCapClock), .crystalClock(crystalClock),
		.clockInPinInputEnable(clockInPinInputEnable), .clockOutPinOut(clockOutPinOut),
		.clockOutPinOe(clockOutPinOe), .crystalAmpEnable(crystalAmpEnable),
		.externalClockEngaged(externalClockEngaged), .internalOscRunning(internalOscRunning));
	ocs_src_model u_src (.runPin(runPin), .runRc(runRc), .runXtal(runXtal), .pinClk(clockInPinIn),
		.resistor_cap_clock(resistorCapClock), .crystal_clock(crystalClock));

	// edge counters; the run is cut short well past the expected length
	always @(posedge ref_clk) begin
		quadPrev <= busClockQuad;
		dblPrev <= busClockDouble;
		outPrev <= clockOutPinOut;
		quadRises <= quadRises + int'(busClockQuad & ~quadPrev);
		dblRises <= dblRises + int'(busClockDouble & ~dblPrev);
		outRises <= outRises + int'(clockOutPinOut & ~outPrev);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			stop_test;
		end
	end
	always @(posedge clockInPinIn) pinRises++;
	always @(posedge resistorCapClock) rcRises++;
	always @(posedge crystalClock) xtalRises++;

	task automatic stop_test;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic near(input int a, input int b, input int tol);
		return (a - b <= tol) && (b - a <= tol);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		#1;
		rdv = regRdData;
	endtask
	task automatic meas(input int n);
		#1;
		quadRises = 0;
		dblRises = 0;
		outRises = 0;
		pinRises = 0;
		rcRises = 0;
		xtalRises = 0;
		tick(n);
	endtask
	task automatic waitEng(input logic v, input int maxc);
		int i;
		for (i = 0; i < maxc && externalClockEngaged !== v; i++)
			tick(1);
		chk(externalClockEngaged, v);
	endtask
	task automatic fmeas(input logic [7:0] ctrl, input logic [7:0] trim, output int c);
		wr(8'h00, ctrl);
		wr(8'h01, trim);
		meas(1000);
		c = quadRises;
		chk(near(dblRises * 2, quadRises, 2), 1'b1);
	endtask

	task automatic t_reset;
		rd(8'h00);
		chk(rdv, 8'h00);
		rd(8'h01);
		chk(rdv, 8'h00);
		rd(8'h07);
		chk(rdv, 8'h00);
		chk(externalClockEngaged, 1'b0);
		chk(clockInPinInputEnable, 1'b0);
		wr(8'h01, 8'ha5);
		rd(8'h01);
		chk(rdv, 8'ha5);
		wr(8'h00, 8'h01);
		rd(8'h00);
		chk(rdv, 8'h00);
	endtask
	task automatic t_freq;
		fmeas(8'h00, 8'h00, c4);
		fmeas(8'h10, 8'h00, c8);
		fmeas(8'h20, 8'h00, c12);
		fmeas(8'h00, 8'h7f, cHi);
		fmeas(8'h00, 8'h80, cLo);
		chk(near(c8, 2 * c4, 4), 1'b1);
		chk(near(c12 * 10, c4 * 32, 80), 1'b1);
		chk(cHi + 5 < c4, 1'b1);
		chk(cLo > c4 + 5, 1'b1);
		wr(8'h01, 8'h00);
	endtask
	task automatic t_pin_int;
		wr(8'h02, 8'h01);
		tick(3);
		chk(clockOutPinOe, 1'b1);
		meas(300);
		chk(near(outRises, quadRises, 1), 1'b1);
		wr(8'h02, 8'h00);
		tick(3);
		chk(clockOutPinOe, 1'b0);
	endtask
	task automatic t_ext;
		wr(8'h00, 8'h40);
		wr(8'h02, 8'h01);
		tick(3);
		chk(clockInPinInputEnable, 1'b1);
		chk(clockOutPinOe, 1'b0);
		rd(8'h02);
		chk(rdv[0], 1'b0);
		tick(20);
		wr(8'h00, 8'h42);
		tick(40);
		chk(externalClockEngaged, 1'b0);
		runPin <= 1'b1;
		tick(6);
		chk(externalClockEngaged, 1'b0);
		waitEng(1'b1, 40);
		chk(internalOscRunning, 1'b1);
		tick(1);
		chk(internalOscRunning, 1'b0);
		meas(700);
		chk(near(quadRises, pinRises, 2), 1'b1);
		chk(near(dblRises * 2, quadRises, 2), 1'b1);
		wr(8'h00, 8'h00);
		waitEng(1'b0, 100);
		tick(2);
		chk(internalOscRunning, 1'b1);
		chk(clockInPinInputEnable, 1'b0);
		runPin <= 1'b0;
		wr(8'h02, 8'h00);
	endtask
	task automatic t_rc;
		wr(8'h00, 8'h80);
		runRc <= 1'b1;
		tick(20);
		wr(8'h00, 8'h82);
		waitEng(1'b1, 60);
		wr(8'h02, 8'h01);
		meas(900);
		chk(near(quadRises, rcRises, 2), 1'b1);
		chk(clockOutPinOe, 1'b1);
		chk(near(outRises, quadRises, 1), 1'b1);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h00);
		waitEng(1'b0, 100);
		runRc <= 1'b0;
	endtask
	task automatic t_xtal;
		wr(8'h02, 8'h01);
		wr(8'h00, 8'hc4);
		tick(3);
		chk(crystalAmpEnable, 1'b1);
		chk(clockOutPinOe, 1'b0);
		chk(clockInPinInputEnable, 1'b1);
		rd(8'h00);
		chk(rdv, 8'hc4);
		runXtal <= 1'b1;
		tick(20);
		wr(8'h00, 8'hc6);
		waitEng(1'b1, 60);
		meas(600);
		chk(near(quadRises, xtalRises, 2), 1'b1);
		chk(clockOutPinOe, 1'b0);
		wr(8'h00, 8'h00);
		waitEng(1'b0, 100);
		runXtal <= 1'b0;
		wr(8'h02, 8'h00);
		tick(3);
		chk(crystalAmpEnable, 1'b0);
	endtask
	task automatic t_stop;
		@(posedge ref_clk);
		systemOscEnable <= 1'b0;
		tick(3);
		chk(internalOscRunning, 1'b0);
		meas(200);
		chk(quadRises, 0);
		wr(8'h02, 8'h02);
		meas(200);
		chk(internalOscRunning, 1'b1);
		chk(quadRises > 5, 1'b1);
		@(posedge ref_clk);
		systemOscEnable <= 1'b1;
		wr(8'h02, 8'h00);
		meas(200);
		chk(quadRises > 5, 1'b1);
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_freq;
		t_pin_int;
		t_ext;
		t_rc;
		t_xtal;
		t_stop;
		stop_test;
	end
endmodule
